// ### core/aiss_adc_i2c_slave_sequencer.sv
// digital sequencer and two-wire slave port of the delta-sigma converter
`timescale 1ns/1ps
module aiss_adc_i2c_slave_sequencer #(
	parameter logic [3:0]  ADDR_BASE    = 4'h2,   // arbitrary upper address bits
	parameter int unsigned INT_TICK_DIV = 130
) (
	// system
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// two-wire bus
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// address select pins
	input  wire logic [1:0]  addr_pin_tristate,
	input  wire logic        addr_or_clock_pin,
	// converter core
	input  wire logic        conv_done,
	input  wire logic [31:0] conv_word,
	input  wire logic        conv_over,
	input  wire logic        conv_under,
	output logic             conv_run,
	output logic             conv_start,
	output logic             conv_tick,
	output logic             filter_null_tick,
	// configuration and status
	output logic             temp_input_sel,
	output logic             line_reject_sel_a,
	output logic             line_reject_sel_b,
	output logic             double_rate_sel,
	output logic             ext_clock_mode,
	output logic             sleep_mode
);

	localparam int unsigned TW = $clog2(INT_TICK_DIV);
	localparam int unsigned NW = $clog2(aiss_pkg::FILTER_NULL_DIV);

	if (INT_TICK_DIV < 2)
	begin : g_bad_div
		$error("internal tick divider must be at least two");
	end

	// synchronised pins
	logic [4:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic [1:0] ca1_s;
	logic       ca0_s;

	aiss_sync #(
		.W (5)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d       ({scl_in, sda_in, addr_pin_tristate, addr_or_clock_pin}),
		.q       (pins_s)
	);

	assign scl_s = pins_s[4];
	assign sda_s = pins_s[3];
	assign ca1_s = pins_s[2:1];
	assign ca0_s = pins_s[0];

	logic ext_rise;

	aiss_clk_detect #(
		.TIMEOUT_CYC (aiss_pkg::EXT_TIMEOUT_CYC)
	) u_clk_detect (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.pin_s    (ca0_s),
		.ext_mode (ext_clock_mode),
		.ext_rise (ext_rise)
	);

	// bus condition decode
	logic scl_p_q;
	logic sda_p_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_rise  = scl_s & ~scl_p_q;
	assign scl_fall  = ~scl_s & scl_p_q;
	assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// own address
	logic [1:0] ca1_code;
	logic       ca0_bit;
	logic [6:0] own_addr;

	assign ca1_code = (ca1_s == aiss_pkg::TRI_HIGH)  ? 2'h1 :
	                  (ca1_s == aiss_pkg::TRI_FLOAT) ? 2'h2 : 2'h0;
	assign ca0_bit  = ext_clock_mode | ca0_s;
	assign own_addr = {ADDR_BASE, ca1_code, ca0_bit};

	// state
	aiss_pkg::aiss_seq_type seq_q;
	aiss_pkg::aiss_seq_type seq_d;
	aiss_pkg::aiss_bus_type bus_q;
	aiss_pkg::aiss_bus_type bus_d;
	logic [3:0]   bit_cnt_q;
	logic [3:0]   bit_cnt_d;
	logic [1:0]   byte_cnt_q;
	logic [1:0]   byte_cnt_d;
	logic [7:0]   shin_q;
	logic [7:0]   shin_d;
	logic [31:0]  tx_q;
	logic [31:0]  tx_d;
	logic [31:0]  result_q;
	logic [31:0]  result_d;
	logic [7:0]   cfg_q;
	logic [7:0]   cfg_d;
	logic [7:0]   new_cfg_q;
	logic [7:0]   new_cfg_d;
	logic         rw_q;
	logic         rw_d;
	logic         oe_q;
	logic         oe_d;
	logic         mack_q;
	logic         mack_d;
	logic         wr_pend_q;
	logic         wr_pend_d;
	logic         conv_req;
	logic         addr_hit;

	logic ready;
	logic addr_match;
	logic byte_full;
	logic cfg_valid;
	logic last_byte;

	assign ready      = (seq_q != aiss_pkg::SEQ_CONVERT);
	assign addr_match = (shin_q[7:1] == own_addr);
	assign byte_full  = (bit_cnt_q == 4'(aiss_pkg::BYTE_BITS));
	assign last_byte  = (byte_cnt_q == 2'(aiss_pkg::BYTES_PER_READ - 1));
	assign cfg_valid  = (shin_q[aiss_pkg::CFG_RSVD_MSB:aiss_pkg::CFG_RSVD_LSB] == 4'h0)
	                    & ~(shin_q[aiss_pkg::CFG_REJ_A_BIT] & shin_q[aiss_pkg::CFG_REJ_B_BIT]);

	// bus protocol engine; all decisions are made on synchronised edges
	always_comb
	begin
		bus_d      = bus_q;
		bit_cnt_d  = bit_cnt_q;
		byte_cnt_d = byte_cnt_q;
		shin_d     = shin_q;
		tx_d       = tx_q;
		rw_d       = rw_q;
		oe_d       = oe_q;
		mack_d     = mack_q;
		wr_pend_d  = wr_pend_q;
		new_cfg_d  = new_cfg_q;
		cfg_d      = cfg_q;
		conv_req   = 1'b0;
		addr_hit   = 1'b0;
		if (start_det)
		begin
			bus_d     = aiss_pkg::BUS_ADDR;
			bit_cnt_d = 4'h0;
			oe_d      = 1'b0;
		end
		else if (stop_det)
		begin
			bus_d     = aiss_pkg::BUS_IDLE;
			oe_d      = 1'b0;
			wr_pend_d = 1'b0;
			if (wr_pend_q)
			begin
				cfg_d    = new_cfg_q;
				conv_req = 1'b1;
			end
		end
		else
		begin
			unique case (bus_q)
				aiss_pkg::BUS_IDLE:
				begin
				end
				aiss_pkg::BUS_ADDR:
				begin
					if (scl_rise)
					begin
						shin_d    = {shin_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end
					else if (scl_fall && byte_full)
					begin
						bit_cnt_d = 4'h0;
						if (addr_match && ready)
						begin
							bus_d    = aiss_pkg::BUS_ADDR_ACK;
							oe_d     = 1'b1;
							rw_d     = shin_q[0];
							tx_d     = result_q;
							addr_hit = 1'b1;
						end
						else
							bus_d = aiss_pkg::BUS_IDLE;
					end
				end
				aiss_pkg::BUS_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						byte_cnt_d = 2'h0;
						if (rw_q)
						begin
							bus_d = aiss_pkg::BUS_RD_DATA;
							oe_d  = ~tx_q[31];
						end
						else
						begin
							bus_d = aiss_pkg::BUS_WR_DATA;
							oe_d  = 1'b0;
						end
					end
				end
				aiss_pkg::BUS_RD_DATA:
				begin
					if (scl_fall)
					begin
						bit_cnt_d = bit_cnt_q + 4'h1;
						tx_d      = {tx_q[30:0], 1'b0};
						if (bit_cnt_q == 4'(aiss_pkg::BYTE_BITS - 1))
						begin
							bus_d = aiss_pkg::BUS_RD_ACK;
							oe_d  = 1'b0;
						end
						else
							oe_d = ~tx_q[30];
					end
				end
				aiss_pkg::BUS_RD_ACK:
				begin
					if (scl_rise)
						mack_d = sda_s;
					else if (scl_fall)
					begin
						bit_cnt_d = 4'h0;
						if (last_byte)
						begin
							bus_d    = aiss_pkg::BUS_IDLE;
							conv_req = 1'b1;
						end
						else if (!mack_q)
						begin
							bus_d      = aiss_pkg::BUS_RD_DATA;
							byte_cnt_d = byte_cnt_q + 2'h1;
							oe_d       = ~tx_q[31];
						end
						else
							bus_d = aiss_pkg::BUS_IDLE;
					end
				end
				aiss_pkg::BUS_WR_DATA:
				begin
					if (scl_rise)
					begin
						shin_d    = {shin_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end
					else if (scl_fall && byte_full)
					begin
						bus_d     = aiss_pkg::BUS_WR_ACK;
						bit_cnt_d = 4'h0;
						oe_d      = 1'b1;
					end
				end
				aiss_pkg::BUS_WR_ACK:
				begin
					if (scl_fall)
					begin
						// further bytes are ignored until the next start
						bus_d     = aiss_pkg::BUS_IDLE;
						oe_d      = 1'b0;
						wr_pend_d = cfg_valid;
						new_cfg_d = shin_q;
					end
				end
				default:
				begin
					bus_d = aiss_pkg::BUS_IDLE;
					oe_d  = 1'b0;
				end
			endcase
		end
	end

	assign result_d = conv_over  ? aiss_pkg::OVER_CODE  :
	                  conv_under ? aiss_pkg::UNDER_CODE : conv_word;

	always_comb
	begin
		seq_d = seq_q;
		unique case (seq_q)
			aiss_pkg::SEQ_CONVERT:
			begin
				if (conv_done)
					seq_d = aiss_pkg::SEQ_SLEEP;
			end
			aiss_pkg::SEQ_SLEEP:
			begin
				if (addr_hit)
					seq_d = aiss_pkg::SEQ_IO;
			end
			aiss_pkg::SEQ_IO:
			begin
				if (conv_req)
					seq_d = aiss_pkg::SEQ_CONVERT;
				else if (stop_det)
					seq_d = aiss_pkg::SEQ_SLEEP;
			end
			default:
				seq_d = aiss_pkg::SEQ_CONVERT;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			scl_p_q    <= 1'b1;
			sda_p_q    <= 1'b1;
			bus_q      <= aiss_pkg::BUS_IDLE;
			bit_cnt_q  <= 4'h0;
			byte_cnt_q <= 2'h0;
			shin_q     <= 8'h00;
			tx_q       <= 32'h00000000;
			rw_q       <= 1'b0;
			oe_q       <= 1'b0;
			mack_q     <= 1'b1;
			wr_pend_q  <= 1'b0;
			new_cfg_q  <= aiss_pkg::CFG_RESET;
		end
		else
		begin
			scl_p_q    <= scl_s;
			sda_p_q    <= sda_s;
			bus_q      <= bus_d;
			bit_cnt_q  <= bit_cnt_d;
			byte_cnt_q <= byte_cnt_d;
			shin_q     <= shin_d;
			tx_q       <= tx_d;
			rw_q       <= rw_d;
			oe_q       <= oe_d;
			mack_q     <= mack_d;
			wr_pend_q  <= wr_pend_d;
			new_cfg_q  <= new_cfg_d;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			seq_q      <= aiss_pkg::SEQ_CONVERT;
			cfg_q      <= aiss_pkg::CFG_RESET;
			result_q   <= 32'h00000000;
			conv_start <= 1'b1;
		end
		else
		begin
			seq_q      <= seq_d;
			cfg_q      <= cfg_d;
			conv_start <= conv_req;
			if (seq_q == aiss_pkg::SEQ_CONVERT && conv_done)
				result_q <= result_d;
		end
	end

	assign sleep_mode = (seq_q == aiss_pkg::SEQ_SLEEP);
	assign conv_run   = (seq_q == aiss_pkg::SEQ_CONVERT);

	assign sda_out = 1'b0;
	assign sda_oe  = oe_q;

	assign temp_input_sel    = cfg_q[aiss_pkg::CFG_TEMP_BIT];
	assign line_reject_sel_a = cfg_q[aiss_pkg::CFG_REJ_A_BIT];
	assign line_reject_sel_b = cfg_q[aiss_pkg::CFG_REJ_B_BIT];
	// the temperature input always runs at normal speed
	assign double_rate_sel   = cfg_q[aiss_pkg::CFG_RATE_BIT] & ~cfg_q[aiss_pkg::CFG_TEMP_BIT];

	// conversion clock: internal divider or the external pin edges
	logic [TW-1:0] int_cnt_q;
	logic [NW-1:0] null_cnt_q;
	logic          int_tick;
	logic          tick_src;
	logic          null_wrap;

	assign int_tick  = (int_cnt_q == TW'(INT_TICK_DIV - 1));
	assign tick_src  = ext_clock_mode ? ext_rise : int_tick;
	assign null_wrap = (null_cnt_q == NW'(aiss_pkg::FILTER_NULL_DIV - 1));

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			int_cnt_q        <= '0;
			null_cnt_q       <= '0;
			conv_tick        <= 1'b0;
			filter_null_tick <= 1'b0;
		end
		else
		begin
			int_cnt_q        <= int_tick ? '0 : int_cnt_q + TW'(1);
			conv_tick        <= tick_src;
			filter_null_tick <= tick_src & null_wrap;
			if (tick_src)
				null_cnt_q <= null_wrap ? '0 : null_cnt_q + NW'(1);
		end
	end

endmodule // aiss_adc_i2c_slave_sequencer

// ### core/aiss_pkg.sv
// shared constants for the converter sequencer and its two-wire slave port
package aiss_pkg;

	// system clock and timing
	localparam int unsigned CLK_HZ             = 40_000_000;
	localparam int unsigned EXT_MIN_FREQ_HZ    = 10_000;
	// longest gap between external clock edges, rounded down to whole cycles
	localparam int unsigned EXT_TIMEOUT_CYC    = CLK_HZ / EXT_MIN_FREQ_HZ;
	localparam int unsigned FILTER_NULL_DIV    = 5120;

	// transfer geometry
	localparam int unsigned RESULT_BITS        = 32;
	localparam int unsigned BYTE_BITS          = 8;
	localparam int unsigned BYTES_PER_READ     = 4;
	localparam int unsigned ADDR_BITS          = 7;

	// configuration byte, bit positions as received msb first
	localparam int unsigned CFG_RSVD_MSB       = 7;
	localparam int unsigned CFG_RSVD_LSB       = 4;
	localparam int unsigned CFG_TEMP_BIT       = 3;
	localparam int unsigned CFG_REJ_A_BIT      = 2;
	localparam int unsigned CFG_REJ_B_BIT      = 1;
	localparam int unsigned CFG_RATE_BIT       = 0;
	localparam logic [7:0]  CFG_RESET          = 8'h00;

	// out-of-range result codes
	localparam logic [31:0] OVER_CODE          = 32'hC0000000;
	localparam logic [31:0] UNDER_CODE         = 32'h3FFFFFFF;

	// three-level address pin codes from the pad sensor
	localparam logic [1:0]  TRI_LOW            = 2'h0;
	localparam logic [1:0]  TRI_HIGH           = 2'h1;
	localparam logic [1:0]  TRI_FLOAT          = 2'h2;

	typedef enum logic [1:0] {
		SEQ_CONVERT = 2'h0,
		SEQ_SLEEP   = 2'h1,
		SEQ_IO      = 2'h3
	} aiss_seq_type;

	typedef enum logic [2:0] {
		BUS_IDLE     = 3'h0,
		BUS_ADDR     = 3'h1,
		BUS_ADDR_ACK = 3'h3,
		BUS_WR_DATA  = 3'h2,
		BUS_WR_ACK   = 3'h6,
		BUS_RD_DATA  = 3'h7,
		BUS_RD_ACK   = 3'h5
	} aiss_bus_type;

endpackage

// ### core/aiss_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module aiss_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// pins and synchronised copy
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_q;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s1_q <= '0;
			q    <= '0;
		end
		else
		begin
			s1_q <= d;
			q    <= s1_q;
		end
	end

endmodule // aiss_sync

// ### core/aiss_clk_detect.sv
// decides whether the dual-purpose address pin carries a clock
`timescale 1ns/1ps
module aiss_clk_detect #(
	parameter int unsigned TIMEOUT_CYC = aiss_pkg::EXT_TIMEOUT_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// synchronised pin level
	input  wire logic pin_s,
	// detection result
	output logic      ext_mode,
	output logic      ext_rise
);

	localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

	if (TIMEOUT_CYC < 2)
	begin : g_bad_timeout
		$error("timeout must be at least two cycles");
	end

	logic          pin_p_q;
	logic [CW-1:0] gap_q;
	logic          rise;
	logic          expired;

	assign rise     = pin_s & ~pin_p_q;
	assign expired  = (gap_q == CW'(TIMEOUT_CYC));
	assign ext_rise = rise & ext_mode;

	// the pin counts as a clock only while rising edges keep coming within the timeout
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pin_p_q  <= 1'b0;
			gap_q    <= '0;
			ext_mode <= 1'b0;
		end
		else
		begin
			pin_p_q <= pin_s;
			if (rise)
			begin
				ext_mode <= ~expired;
				gap_q    <= '0;
			end
			else if (expired)
				ext_mode <= 1'b0;
			else
				gap_q <= gap_q + CW'(1);
		end
	end

endmodule // aiss_clk_detect

// ### verification/aiss_seq_sva.sv
// port checker for the converter sequencer and its slave port
`timescale 1ns/1ps
module aiss_seq_sva (
	// system
	input wire logic clk_sys,
	input wire logic rst,
	// bus
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// converter
	input wire logic conv_done,
	input wire logic conv_run,
	input wire logic conv_start,
	input wire logic conv_tick,
	input wire logic filter_null_tick,
	// configuration and status
	input wire logic temp_input_sel,
	input wire logic line_reject_sel_a,
	input wire logic line_reject_sel_b,
	input wire logic double_rate_sel,
	input wire logic sleep_mode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_done;
		conv_run && conv_done;
	endsequence
	sequence s_sleep;
		sleep_mode && !conv_run;
	endsequence

	property p_open_drain; sda_oe |-> sda_out == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
	property p_no_ack_conv; conv_run |-> !sda_oe; endproperty
	a_no_ack_conv: assert property (p_no_ack_conv) else $error("bus driven while converting");
	property p_start_pulse; conv_start |=> conv_run && !conv_start; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("bad conversion start");
	property p_done_sleep; s_done |=> s_sleep; endproperty
	a_done_sleep: assert property (p_done_sleep) else $error("no sleep after conversion");
	property p_sleep_wait; s_sleep |=> !conv_run; endproperty
	a_sleep_wait: assert property (p_sleep_wait) else $error("sleep left for conversion");
	property p_conv_hold; conv_run && !conv_done |=> conv_run; endproperty
	a_conv_hold: assert property (p_conv_hold) else $error("conversion abandoned");
	property p_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
	a_scl_low: assert property (p_scl_low) else $error("data changed with clock high");
	property p_sync; $fell(scl_in) |-> $stable(sda_oe) [*3]; endproperty
	a_sync: assert property (p_sync) else $error("data answered before sync");
	property p_temp_speed; temp_input_sel |-> !double_rate_sel; endproperty
	a_temp_speed: assert property (p_temp_speed) else $error("double rate in temp mode");
	property p_cfg_start;
		$changed({temp_input_sel, line_reject_sel_a, line_reject_sel_b, double_rate_sel})
			|-> conv_start;
	endproperty
	a_cfg_start: assert property (p_cfg_start) else $error("config changed without write");
	property p_null_tick; filter_null_tick |-> conv_tick; endproperty
	a_null_tick: assert property (p_null_tick) else $error("null tick off the conversion clock");
endmodule // aiss_seq_sva

bind aiss_adc_i2c_slave_sequencer aiss_seq_sva i_aiss_seq_sva (.clk_sys(clk_sys), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
	.conv_run(conv_run), .conv_start(conv_start), .temp_input_sel(temp_input_sel),
	.conv_tick(conv_tick), .filter_null_tick(filter_null_tick),
	.line_reject_sel_a(line_reject_sel_a), .line_reject_sel_b(line_reject_sel_b),
	.double_rate_sel(double_rate_sel), .sleep_mode(sleep_mode));

// ### verification/aiss_bus_master.sv
// two-wire bus master model facing the slave port
`timescale 1ns/1ps
module aiss_bus_master (
	// clock
	input  wire logic clk_sys,
	// bus wires
	input  wire logic sda_line,
	output logic      scl_low,
	output logic      sda_low
);
	// quarter of a 400 kHz bit time
	localparam int Q = 25;

	initial
	begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	task automatic wq();
		repeat (Q) @(negedge clk_sys);
	endtask

	task automatic start();
		sda_low = 1'b0;
		wq();
		scl_low = 1'b0;
		wq();
		sda_low = 1'b1;
		wq();
		scl_low = 1'b1;
		wq();
	endtask

	task automatic stop();
		sda_low = 1'b1;
		wq();
		scl_low = 1'b0;
		wq();
		sda_low = 1'b0;
		wq();
	endtask

	// set while low, sample mid high
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		wq();
		scl_low = 1'b0;
		wq();
		r = sda_line;
		wq();
		scl_low = 1'b1;
		wq();
	endtask

	task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bit_io(d[i], r[i]);
	endtask
endmodule // aiss_bus_master

// ### verification/aiss_adc_i2c_slave_sequencer_tb.sv
// self-checking bench for the converter sequencer and slave port
`timescale 1ns/1ps
module aiss_adc_i2c_slave_sequencer_tb;
	localparam logic [3:0] BASE = 4'h9;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [1:0]  addr_pin_tristate = 2'h0;
	logic        addr_or_clock_pin = 1'b0;
	logic        conv_done = 1'b0;
	logic [31:0] conv_word = 32'h0;
	logic        conv_over = 1'b0;
	logic        conv_under = 1'b0;
	logic        scl_low, sda_low, sda_out, sda_oe, conv_run, conv_start, conv_tick;
	logic        filter_null_tick, temp_input_sel, line_reject_sel_a, line_reject_sel_b;
	logic        double_rate_sel, ext_clock_mode, sleep_mode;
	logic [8:0]  r;
	int          error_cnt = 0;
	int          cmp_count = 0;
	wire         scl_in = !scl_low;
	// open drain with pull-up: a released line reads high
	wire         sda_in = !sda_low && !(sda_oe && !sda_out);

	always #12.5 clk_sys = ~clk_sys;

	aiss_adc_i2c_slave_sequencer #(.ADDR_BASE(BASE), .INT_TICK_DIV(16))
		i_aiss_adc_i2c_slave_sequencer (.clk_sys(clk_sys), .rst(rst), .scl_in(scl_in),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_pin_tristate(addr_pin_tristate), .addr_or_clock_pin(addr_or_clock_pin),
		.conv_done(conv_done), .conv_word(conv_word), .conv_over(conv_over),
		.conv_under(conv_under), .conv_run(conv_run), .conv_start(conv_start),
		.conv_tick(conv_tick), .filter_null_tick(filter_null_tick),
		.temp_input_sel(temp_input_sel), .line_reject_sel_a(line_reject_sel_a),
		.line_reject_sel_b(line_reject_sel_b), .double_rate_sel(double_rate_sel),
		.ext_clock_mode(ext_clock_mode), .sleep_mode(sleep_mode));
	aiss_bus_master i_aiss_bus_master (.clk_sys(clk_sys), .sda_line(sda_in),
		.scl_low(scl_low), .sda_low(sda_low));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic clk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	function automatic logic [6:0] adr(input logic [1:0] c, input logic z);
		return {BASE, c, z};
	endfunction

	// core stand-in; the word is scrambled after the pulse so a late capture shows
	task automatic finish_conv(input logic [31:0] w, input logic ov, input logic un);
		check("conv_run before done", conv_run, 1'b1);
		conv_word = w;
		conv_over = ov;
		conv_under = un;
		conv_done = 1'b1;
		clk(1);
		conv_done = 1'b0;
		conv_word = ~w;
		conv_over = 1'b0;
		conv_under = 1'b0;
		clk(2);
	endtask

	task automatic address(input logic [6:0] a, input logic rd, input logic ack);
		i_aiss_bus_master.xbyte({a, rd, 1'b1}, r);
		check("address ack", !r[0], ack);
	endtask

	// the last byte is refused by the master
	task automatic read_word(input logic [31:0] exp, input int nbytes);
		for (int i = 0; i < nbytes; i++)
		begin
			i_aiss_bus_master.xbyte({8'hFF, i == nbytes - 1}, r);
			check("read byte", r[8:1], exp[31 - 8 * i -: 8]);
		end
	endtask

	task automatic t_reset();
		check("conv_run", conv_run, 1'b1);
		check("sleep_mode", sleep_mode, 1'b0);
		check("cfg", {temp_input_sel, line_reject_sel_a, line_reject_sel_b, double_rate_sel}, 4'h0);
		i_aiss_bus_master.start();
		address(adr(2'h0, 1'b0), 1'b1, 1'b0);
		i_aiss_bus_master.stop();
		$display("test reset done");
	endtask

	task automatic t_read();
		finish_conv(32'hA5C33C5A, 1'b0, 1'b0);
		check("sleep_mode", sleep_mode, 1'b1);
		clk(300);
		check("conv_run", conv_run, 1'b0);
		i_aiss_bus_master.start();
		address(adr(2'h0, 1'b0), 1'b1, 1'b1);
		read_word(32'hA5C33C5A, 4);
		check("conv_run", conv_run, 1'b1);
		i_aiss_bus_master.start();
		address(adr(2'h0, 1'b0), 1'b1, 1'b0);
		i_aiss_bus_master.stop();
		$display("test read done");
	endtask

	task automatic t_range();
		for (int k = 0; k < 2; k++)
		begin
			finish_conv(32'h12345678, k == 0, k == 1);
			i_aiss_bus_master.start();
			address(adr(2'h0, 1'b0), 1'b1, 1'b1);
			read_word(k ? 32'h3FFFFFFF : 32'hC0000000, 1);
			i_aiss_bus_master.start();
			address(adr(2'h0, 1'b0), 1'b1, 1'b1);
			read_word(k ? 32'h3FFFFFFF : 32'hC0000000, 4);
			i_aiss_bus_master.stop();
		end
		$display("test range done");
	endtask

	task automatic t_write();
		logic [7:0] cfg [5] = '{8'h05, 8'h0A, 8'h09, 8'h12, 8'h06};
		logic [3:0] exp_cfg;
		logic       valid;
		exp_cfg = 4'h0;
		foreach (cfg[i])
		begin
			valid = cfg[i][7:4] == 4'h0 && cfg[i][2:1] != 2'h3;
			if (conv_run)
				finish_conv(32'h7E000000, 1'b0, 1'b0);
			i_aiss_bus_master.start();
			address(adr(2'h0, 1'b0), 1'b0, 1'b1);
			i_aiss_bus_master.xbyte({cfg[i], 1'b1}, r);
			check("config ack", !r[0], 1'b1);
			i_aiss_bus_master.xbyte({8'h5A, 1'b1}, r);
			check("extra byte ack", !r[0], 1'b0);
			i_aiss_bus_master.stop();
			clk(8);
			if (valid)
				exp_cfg = {cfg[i][3:1], cfg[i][0] & !cfg[i][3]};
			check("conv_run", conv_run, valid);
			check("cfg", {temp_input_sel, line_reject_sel_a, line_reject_sel_b, double_rate_sel}, exp_cfg);
		end
		$display("test write done");
	endtask

	task automatic t_addr();
		for (int c = 0; c < 3; c++)
			for (int z = 0; z < 2; z++)
			begin
				addr_pin_tristate = c[1:0];
				addr_or_clock_pin = z[0];
				clk(4100);
				check("ext_clock_mode", ext_clock_mode, 1'b0);
				i_aiss_bus_master.start();
				address(adr(c[1:0], z[0]) ^ 7'h06, 1'b1, 1'b0);
				i_aiss_bus_master.start();
				address(adr(c[1:0], z[0]), 1'b1, 1'b1);
				read_word(32'h7E000000, 1);
				i_aiss_bus_master.stop();
			end
		$display("test address done");
	endtask

	task automatic t_ext();
		addr_pin_tristate = 2'h0;
		addr_or_clock_pin = 1'b0;
		clk(4100);
		fork
			repeat (30)
			begin
				clk(100);
				addr_or_clock_pin = !addr_or_clock_pin;
			end
			begin
				clk(500);
				check("ext_clock_mode", ext_clock_mode, 1'b1);
				i_aiss_bus_master.start();
				address(adr(2'h0, 1'b1), 1'b1, 1'b1);
				read_word(32'h7E000000, 1);
				i_aiss_bus_master.stop();
			end
		join
		clk(4100);
		check("ext_clock_mode", ext_clock_mode, 1'b0);
		$display("test external clock done");
	endtask

	// internal divider paces the conversion clock while the pin is quiet
	task automatic t_tick();
		int n;
		n = 0;
		while (conv_tick !== 1'b1 && n < 40)
		begin
			clk(1);
			n++;
		end
		n = 0;
		do
		begin
			clk(1);
			n++;
		end
		while (conv_tick !== 1'b1 && n < 40);
		check("conv_tick gap", n, 32'h00000010);
		if (n >= 40)
			close_out();
		$display("test tick done");
	endtask

	initial
	begin
		clk(3);
		rst = 1'b0;
		clk(4);
		t_reset();
		t_tick();
		t_read();
		t_range();
		t_write();
		t_addr();
		t_ext();
		close_out();
	end
endmodule // aiss_adc_i2c_slave_sequencer_tb
